// ---- core/redundant_supply_select.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1: primary_path_select_n goes low only when converter_enable_n is low and primary threshold is high.
// R2: external_path_select_n is built the same way from the external threshold and converter_enable_n.
// R3: both path selects are evaluated independently; both may be low or both high together.
// R4: converter_enable_n is low only while host enable is high and power_good_n is low.
// R5: converter_enable_n leaves reset high and goes low only when the converter is to turn on.
// R6: a 1 on primary_path_select_n turns the OR transistor off, a 0 turns it on.
// R7: power_good_n asserts only after power-up completes, and feeds the converter enable logic.
// R8: external_path_select_n equals inverted external threshold ORed with converter_enable_n.
// R9: power_good_n goes low in the step after the 15.36 ms wait for the rail to reach full value.
// R10: each of the three outputs is registered and follows its equation one clock after its inputs.
module redundant_supply_select #(
    parameter int unsigned RAIL_WAIT_CYCLES = supply_select_pkg::RAIL_WAIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // board pins
    input wire logic primary_current_above_threshold,
    input wire logic external_current_above_threshold,
    input wire logic host_converter_enable,
    input wire logic rail_12v_high,
    output logic primary_path_select_n,
    output logic external_path_select_n,
    output logic converter_enable_n,
    output logic power_good_n
);
    localparam logic [supply_select_pkg::CNT_W-1:0] WAIT_LAST =
        supply_select_pkg::CNT_W'(RAIL_WAIT_CYCLES - 1);
    localparam logic [supply_select_pkg::CNT_W-1:0] CNT_ZERO = '0;

    logic [supply_select_pkg::PIN_W-1:0] pins_s;
    logic pri_s;
    logic ext_s;
    logic host_s;
    logic rail_s;

    // every pin comes from another domain
    pin_sync #(
        .WIDTH(supply_select_pkg::PIN_W)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in({rail_12v_high, host_converter_enable,
                 external_current_above_threshold, primary_current_above_threshold}),
        .pin_sync_out(pins_s)
    );
    assign pri_s = pins_s[supply_select_pkg::PIN_PRI];
    assign ext_s = pins_s[supply_select_pkg::PIN_EXT];
    assign host_s = pins_s[supply_select_pkg::PIN_HOST];
    assign rail_s = pins_s[supply_select_pkg::PIN_RAIL];

    // ---------------- bus slave and control register ----------------
    logic seq_enable_r;
    logic seq_enable_nxt;
    logic fault_clear_r;
    logic fault_clear_nxt;
    logic wait_r;
    logic wait_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] status_word;
    logic req;
    logic done;
    supply_select_pkg::seq_state_t state_r;
    supply_select_pkg::seq_state_t state_nxt;
    logic [supply_select_pkg::CNT_W-1:0] cnt_r;
    logic [supply_select_pkg::CNT_W-1:0] cnt_nxt;
    logic pg_n_r;
    logic pg_n_nxt;
    logic conv_n_r;
    logic conv_n_nxt;
    logic pri_sel_n_r;
    logic pri_sel_n_nxt;
    logic ext_sel_n_r;
    logic ext_sel_n_nxt;

    assign req = avs_read | avs_write;
    // one wait cycle, then the answer edge
    assign done = req & ~wait_r;

    always_comb begin
        status_word = supply_select_pkg::DATA_ZERO;
        status_word[supply_select_pkg::STAT_POWER_GOOD_BIT] = ~pg_n_r;
        status_word[supply_select_pkg::STAT_CONV_ON_BIT] = ~conv_n_r;
        status_word[supply_select_pkg::STAT_PRIMARY_ON_BIT] = ~pri_sel_n_r;
        status_word[supply_select_pkg::STAT_EXTERNAL_ON_BIT] = ~ext_sel_n_r;
        status_word[supply_select_pkg::STAT_FAULT_BIT] =
            (state_r == supply_select_pkg::ST_FAULT);
        status_word[supply_select_pkg::STAT_STATE_LSB +: supply_select_pkg::STAT_STATE_W] =
            state_r;
    end

    // bus next state; unmapped reads give zero, unmapped writes drop
    always_comb begin
        wait_nxt = ~(req & wait_r);
        rdata_nxt = rdata_r;
        seq_enable_nxt = seq_enable_r;
        fault_clear_nxt = 1'b0;
        if (req && wait_r && avs_read) begin
            if (avs_address == supply_select_pkg::CTRL_OFFSET) begin
                rdata_nxt = supply_select_pkg::DATA_ZERO;
                rdata_nxt[supply_select_pkg::CTRL_SEQ_ENABLE_BIT] = seq_enable_r;
            end else if (avs_address == supply_select_pkg::STATUS_OFFSET) begin
                rdata_nxt = status_word;
            end else begin
                rdata_nxt = supply_select_pkg::DATA_ZERO;
            end
        end
        if (done && avs_write && avs_address == supply_select_pkg::CTRL_OFFSET
            && avs_byteenable[0]) begin
            seq_enable_nxt = avs_writedata[supply_select_pkg::CTRL_SEQ_ENABLE_BIT];
            fault_clear_nxt = avs_writedata[supply_select_pkg::CTRL_FAULT_CLEAR_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            seq_enable_r <= supply_select_pkg::CTRL_SEQ_ENABLE_RESET;
            fault_clear_r <= 1'b0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            seq_enable_r <= seq_enable_nxt;
            fault_clear_r <= fault_clear_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // ---------------- power-up sequencer ----------------
    // ramp wait times out to fault; settle wait then power good
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pg_n_nxt = 1'b1;
        case (state_r)
            supply_select_pkg::ST_OFF: begin
                cnt_nxt = CNT_ZERO;
                if (seq_enable_r) begin
                    state_nxt = supply_select_pkg::ST_RAMP;
                end
            end
            supply_select_pkg::ST_RAMP: begin
                cnt_nxt = cnt_r + 1'b1;
                if (rail_s) begin
                    state_nxt = supply_select_pkg::ST_SETTLE;
                    cnt_nxt = CNT_ZERO;
                end else if (cnt_r == WAIT_LAST) begin
                    state_nxt = supply_select_pkg::ST_FAULT;
                end
            end
            supply_select_pkg::ST_SETTLE: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == WAIT_LAST) begin
                    state_nxt = supply_select_pkg::ST_GOOD;
                    pg_n_nxt = 1'b0; // R9
                end
            end
            supply_select_pkg::ST_GOOD: begin
                pg_n_nxt = 1'b0; // R7
            end
            supply_select_pkg::ST_FAULT: begin
                // latched until software clears it
                if (fault_clear_r) begin
                    state_nxt = supply_select_pkg::ST_OFF;
                end
            end
            default: begin
                state_nxt = supply_select_pkg::ST_OFF;
            end
        endcase
        // dropping the enable always powers down, even from fault
        if (!seq_enable_r) begin
            state_nxt = supply_select_pkg::ST_OFF;
            pg_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= supply_select_pkg::ST_OFF;
            cnt_r <= '0;
            pg_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pg_n_r <= pg_n_nxt;
        end
    end

    // ---------------- supervisory equations ----------------
    // free running, not tied to sequencer state
    always_comb begin
        conv_n_nxt = ~(host_s & ~pg_n_r); // R4
        pri_sel_n_nxt = ~pri_s | conv_n_r; // R1 R6
        ext_sel_n_nxt = ~ext_s | conv_n_r; // R2 R8
    end

    // each output one register stage; conv_n_r gates both path selects, which do not gate each other
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            conv_n_r <= 1'b1; // R5
            pri_sel_n_r <= 1'b1;
            ext_sel_n_r <= 1'b1;
        end else begin
            conv_n_r <= conv_n_nxt; // R10
            pri_sel_n_r <= pri_sel_n_nxt; // R3
            ext_sel_n_r <= ext_sel_n_nxt;
        end
    end

    assign converter_enable_n = conv_n_r;
    assign primary_path_select_n = pri_sel_n_r;
    assign external_path_select_n = ext_sel_n_r;
    assign power_good_n = pg_n_r;

    // ---------------- assertions ----------------
    a_primary_connect: assert property ( // R1
        @(posedge ref_clk) disable iff (rst)
        (pri_s && !conv_n_r) |=> !primary_path_select_n)
        else $error("primary path not connected when due");
    a_primary_open: assert property ( // R6
        @(posedge ref_clk) disable iff (rst)
        (!pri_s || conv_n_r) |=> primary_path_select_n)
        else $error("primary path connected without cause");
    a_external_select: assert property ( // R2
        @(posedge ref_clk) disable iff (rst)
        (ext_s && !conv_n_r) |=> !external_path_select_n)
        else $error("external path not connected when due");
    a_external_open: assert property ( // R8
        @(posedge ref_clk) disable iff (rst)
        (!ext_s || conv_n_r) |=> external_path_select_n)
        else $error("external path connected without cause");
    a_both_selected: assert property ( // R3
        @(posedge ref_clk) disable iff (rst)
        (pri_s && ext_s && !conv_n_r) |=> (!primary_path_select_n && !external_path_select_n))
        else $error("path selects not independent");
    a_converter_enable: assert property ( // R4
        @(posedge ref_clk) disable iff (rst)
        ##1 (converter_enable_n == !($past(host_s) && !$past(power_good_n))))
        else $error("converter enable wrong");
    a_reset_inactive: assert property ( // R5
        @(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> (converter_enable_n && power_good_n && primary_path_select_n))
        else $error("outputs not inactive after reset");
    a_good_after_wait: assert property ( // R7
        @(posedge ref_clk) disable iff (rst)
        $fell(power_good_n) |-> ($past(state_r) == supply_select_pkg::ST_SETTLE))
        else $error("power good without completed settle wait");
    a_settle_done: assert property ( // R9
        @(posedge ref_clk) disable iff (rst)
        (state_r == supply_select_pkg::ST_SETTLE && cnt_r == WAIT_LAST && seq_enable_r)
        |=> (!power_good_n && state_r == supply_select_pkg::ST_GOOD))
        else $error("power good late after settle wait");
    a_host_follow: assert property ( // R10
        @(posedge ref_clk) disable iff (rst)
        (!power_good_n && $rose(host_s)) ##1 !power_good_n |-> !converter_enable_n)
        else $error("converter enable not one clock behind host");
    a_bus_answer: assert property (
        @(posedge ref_clk) disable iff (rst)
        (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
endmodule : redundant_supply_select

// ---- common/supply_select_pkg.sv ----
package supply_select_pkg;
    // bus map, byte addresses of whole 32-bit words
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    // control fields
    localparam int CTRL_SEQ_ENABLE_BIT = 0;
    localparam int CTRL_FAULT_CLEAR_BIT = 1;
    localparam logic CTRL_SEQ_ENABLE_RESET = 1'h0;
    // status fields
    localparam int STAT_POWER_GOOD_BIT = 0;
    localparam int STAT_CONV_ON_BIT = 1;
    localparam int STAT_PRIMARY_ON_BIT = 2;
    localparam int STAT_EXTERNAL_ON_BIT = 3;
    localparam int STAT_FAULT_BIT = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_STATE_W = 3;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RAIL_WAIT_NS = 15_360_000;
    localparam int unsigned RAIL_WAIT_CYCLES = RAIL_WAIT_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 21;
    // pin inputs: 0 primary thr, 1 external thr, 2 host enable, 3 rail high
    localparam int PIN_W = 4;
    localparam int PIN_PRI = 0;
    localparam int PIN_EXT = 1;
    localparam int PIN_HOST = 2;
    localparam int PIN_RAIL = 3;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RAMP,
        ST_SETTLE,
        ST_GOOD,
        ST_FAULT
    } seq_state_t;
endpackage : supply_select_pkg

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser per pin; first stage feeds only the second
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= pin_in[i];
                    stable_r <= meta_r;
                end
            end
            assign pin_sync_out[i] = stable_r;
        end
    endgenerate
endmodule : pin_sync

// ---- dv/or_gate_model.sv ----
`timescale 1ns/1ps
// gate drivers and converter on/off clamp as seen from the far side
module or_gate_model (
    input wire logic primary_path_select_n,
    input wire logic external_path_select_n,
    input wire logic converter_enable_n,
    output logic primary_or_on,
    output logic external_or_on,
    output logic converter_on
);
    // a low select turns its OR transistor on, a high one drains the gate
    assign primary_or_on = ~primary_path_select_n;
    assign external_or_on = ~external_path_select_n;
    // enable low lets go of the clamp, so the converter runs
    assign converter_on = ~converter_enable_n;
endmodule : or_gate_model

// ---- dv/redundant_supply_select_tb.sv ----
`timescale 1ns/1ps
module redundant_supply_select_tb;
    localparam int unsigned RW = 20;
    logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic pri_thr, ext_thr, host_en, rail_hi, pri_on, ext_on, conv_on;
    logic primary_path_select_n, external_path_select_n, converter_enable_n, power_good_n;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    redundant_supply_select #(.RAIL_WAIT_CYCLES(RW)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .primary_current_above_threshold(pri_thr),
        .external_current_above_threshold(ext_thr), .host_converter_enable(host_en),
        .rail_12v_high(rail_hi), .primary_path_select_n(primary_path_select_n),
        .external_path_select_n(external_path_select_n),
        .converter_enable_n(converter_enable_n), .power_good_n(power_good_n)
    );
    or_gate_model model_u (
        .primary_path_select_n(primary_path_select_n),
        .external_path_select_n(external_path_select_n),
        .converter_enable_n(converter_enable_n), .primary_or_on(pri_on),
        .external_or_on(ext_on), .converter_on(conv_on)
    );

    // free-running 100 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard, the whole run needs under two hundred cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one bus cycle; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        check("bus answer", n < 50, 32'h1);
        // read data stands at the answer edge; release only after it
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask : bus

    task automatic pins(input logic p, input logic e, input logic h, input logic r);
        @(posedge ref_clk);
        pri_thr <= p;
        ext_thr <= e;
        host_en <= h;
        rail_hi <= r;
    endtask : pins

    task automatic edges(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : edges

    // reset levels, refused accesses, then a ramp that never sees the rail
    task automatic t_reset_fault();
        check("pri sel", primary_path_select_n, 32'h1);
        check("ext sel", external_path_select_n, 32'h1);
        check("conv en", converter_enable_n, 32'h1);
        check("pg", power_good_n, 32'h1);
        bus(1'h0, 4'h8, 32'h0, 4'hF);
        check("unmapped", rd, 32'h0);
        bus(1'h1, 4'h0, 32'h1, 4'h0);
        bus(1'h1, 4'hC, 32'h1, 4'hF);
        bus(1'h0, 4'h0, 32'h0, 4'hF);
        check("ctrl ignored", rd, 32'h0);
        pins(1'h1, 1'h1, 1'h1, 1'h0);
        bus(1'h1, 4'h0, 32'h1, 4'hF);
        edges(RW + 10);
        check("pg fault", power_good_n, 32'h1);
        check("conv fault", converter_enable_n, 32'h1);
        check("pri fault", primary_path_select_n, 32'h1);
        bus(1'h0, 4'h4, 32'h0, 4'hF);
        check("fault stat", {rd[10:8], rd[4]}, 32'h9);
        bus(1'h1, 4'h0, 32'h2, 4'hF);
        bus(1'h0, 4'h4, 32'h0, 4'hF);
        check("cleared", rd[10:8], 32'h0);
    endtask : t_reset_fault

    // full power-up: settle wait, then enable one edge later, then both paths together one edge after that
    task automatic t_powerup();
        int n;
        n = 0;
        pins(1'h1, 1'h1, 1'h1, 1'h1);
        edges(3);
        bus(1'h1, 4'h0, 32'h1, 4'hF);
        do begin
            edges(1);
            n++;
        end while (power_good_n !== 1'h0 && n < 200);
        check("pg wait", n >= RW && n <= RW + 8, 32'h1);
        check("conv lag", converter_enable_n, 32'h1);
        edges(1);
        check("conv on", converter_enable_n, 32'h0);
        check("pri lag", primary_path_select_n, 32'h1);
        edges(1);
        check("pri on", primary_path_select_n, 32'h0);
        check("ext on", external_path_select_n, 32'h0);
        bus(1'h0, 4'h4, 32'h0, 4'hF);
        check("good stat", rd[10:0], 32'h30F);
    endtask : t_powerup

    // every threshold pairing, each path on its own
    task automatic t_combos();
        logic p, e, pp, pe;
        pp = 1'h1;
        pe = 1'h1;
        for (int i = 0; i < 4; i++) begin
            p = i[0];
            e = i[1];
            pins(p, e, 1'h1, 1'h1);
            edges(2);
            // logical not keeps the expected value one bit wide before widening
            check("pri old", primary_path_select_n, !pp);
            check("ext old", external_path_select_n, !pe);
            edges(1);
            check("pri sel", primary_path_select_n, !p);
            check("ext sel", external_path_select_n, !e);
            check("pri gate", pri_on, p);
            pp = p;
            pe = e;
        end
    endtask : t_combos

    // host enable withdrawn and restored, then the sequencer stopped
    task automatic t_host_off();
        pins(1'h1, 1'h1, 1'h0, 1'h1);
        edges(2);
        check("conv hold", converter_enable_n, 32'h0);
        edges(1);
        check("conv off", converter_enable_n, 32'h1);
        edges(1);
        check("pri drop", primary_path_select_n, 32'h1);
        check("conv pin", conv_on, 32'h0);
        pins(1'h1, 1'h1, 1'h1, 1'h1);
        edges(4);
        check("conv back", converter_enable_n, 32'h0);
        bus(1'h1, 4'h0, 32'h0, 4'hF);
        edges(1);
        check("pg off", power_good_n, 32'h1);
        check("conv off lag", converter_enable_n, 32'h0);
        edges(1);
        check("conv stop", converter_enable_n, 32'h1);
    endtask : t_host_off

    initial begin
        rst = 1'h1;
        avs_address = 4'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        pri_thr = 1'h0;
        ext_thr = 1'h0;
        host_en = 1'h0;
        rail_hi = 1'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        edges(1);
        t_reset_fault();
        t_powerup();
        t_combos();
        t_host_off();
        report_and_stop();
    end
endmodule : redundant_supply_select_tb
